// file: design/pup_params.svh
// register offsets, reset values and pin masks for the port u pin block
`ifndef PUP_PARAMS_SVH
`define PUP_PARAMS_SVH
`define PUP_OFF_LATCH     12'h000
`define PUP_OFF_PIN_IN    12'h004
`define PUP_OFF_DIR       12'h008
`define PUP_OFF_RSVD      12'h00c
`define PUP_OFF_PULL_EN   12'h010
`define PUP_OFF_PULL_POL  12'h014
`define PUP_OFF_SLEW      12'h018
`define PUP_RST_BYTE      8'h00
`define PUP_RSVD_VALUE    8'h00
`define PUP_EVEN_MASK     8'h55
`define PUP_ODD_MASK      8'haa
`endif

// file: design/pup_pkg.sv
// types shared by the port u pin block
package pup_pkg;
  // per-pin alternate function requests
  typedef struct packed {
    logic [7:0] sdd_en;    // stall detect drive owns pin
    logic [7:0] sdd_out;   // stall detect drive level
    logic [7:0] pwm_en;    // motor pwm owns pin
    logic [7:0] pwm_out;   // motor pwm level
    logic [7:0] tmr_en;    // timer output compare enabled (even pins)
    logic [7:0] tmr_out;   // timer output level
  } pup_alt_s;
  // per-pin pad controls
  typedef struct packed {
    logic [7:0] out;       // output level
    logic [7:0] oe;        // output enable
    logic [7:0] pull_up;   // pull-up active
    logic [7:0] pull_dn;   // pull-down active
    logic [7:0] slew_lim;  // slew limiting on
    logic [7:0] ibe;       // input buffer enable
  } pup_pad_s;
  // owner of a pin
  typedef enum logic [3:0] {
    PUP_OWN_GPIO = 4'h1,
    PUP_OWN_TMR  = 4'h2,
    PUP_OWN_PWM  = 4'h4,
    PUP_OWN_SDD  = 4'h8
  } pup_owner_e;
endpackage

// file: design/pup_port.sv
// port u pin control: registers, pin ownership and pad controls
//
// Functional notes
// - latch read gives latch where direction bit set, pin otherwise
// - odd pins: stall drive, then pwm, then gpio
// - even pins: stall, pwm, timer, then gpio
// - timer owns even pin only when channel enabled
// - pin input read always returns buffered pins
// - writes to pin input register are ignored
// - direction bit one output, zero input
// - enabled motor pwm forces pin to output
// - enabled timer compare forces even pin output
// - readback may lag direction change two cycles
// - reserved location reads zero, ignores writes
// - pull acts only while pin is input
// - all pull devices disabled after reset
// - polarity one pull-down, zero pull-up
// - polarity also selects active interrupt edge
// - slew bit limits slew, disables input buffer
`timescale 1ns/1ps
`include "pup_params.svh"

module pup_port (
  input  wire logic            clk_sys,     // bus clock
  input  wire logic            rst_b,       // async reset, active low
  input  wire logic            psel,        // apb select
  input  wire logic            penable,     // apb access phase
  input  wire logic            pwrite,      // apb direction
  input  wire logic [11:0]     paddr,       // apb byte address
  input  wire logic [31:0]     pwdata,      // apb write data
  output logic      [31:0]     prdata,      // apb read data
  output logic                 pready,      // apb ready
  output logic                 pslverr,     // apb error
  input  wire pup_pkg::pup_alt_s alt,       // alternate function requests
  input  wire logic [7:0]      pin_in,      // pad input levels (async)
  output pup_pkg::pup_pad_s    pad,         // pad controls
  output logic      [7:0]      edge_rise_sel // per-pin active edge: 1 rising
);

  // software registers, synchroniser and bus state
  logic [7:0] latch_r;       // output latch
  logic [7:0] dir_r;         // direction
  logic [7:0] pull_en_r;     // pull enable
  logic [7:0] pull_pol_r;    // pull polarity
  logic [7:0] slew_r;        // slew control
  logic [7:0] sync1_r;       // synchroniser first stage
  logic [7:0] sync2_r;       // synchronised pin level
  logic [31:0] rdata_r;      // registered read data
  logic       ready_r;       // access answered

  // bus decode
  wire        setup_w   = psel & ~penable;
  wire        access_w  = psel & penable & ready_r;
  wire        wr_w      = access_w & pwrite;
  wire        hit_latch = paddr == `PUP_OFF_LATCH;
  wire        hit_pin   = paddr == `PUP_OFF_PIN_IN;
  wire        hit_dir   = paddr == `PUP_OFF_DIR;
  wire        hit_rsvd  = paddr == `PUP_OFF_RSVD;
  wire        hit_pen   = paddr == `PUP_OFF_PULL_EN;
  wire        hit_pol   = paddr == `PUP_OFF_PULL_POL;
  wire        hit_slew  = paddr == `PUP_OFF_SLEW;
  wire        hit_any   = hit_latch | hit_pin | hit_dir | hit_rsvd | hit_pen | hit_pol | hit_slew;

  // pin ownership per pin
  wire [7:0]  tmr_own   = alt.tmr_en & `PUP_EVEN_MASK;
  wire [7:0]  own_sdd   = alt.sdd_en;
  wire [7:0]  own_pwm   = alt.pwm_en & ~own_sdd;
  wire [7:0]  own_tmr   = tmr_own & ~alt.pwm_en & ~own_sdd;
  wire [7:0]  own_gpio  = ~(own_sdd | own_pwm | own_tmr);

  // effective direction: pwm and timer compare force output
  wire [7:0]  force_out = alt.pwm_en | (tmr_own & ~alt.pwm_en);
  wire [7:0]  is_out    = dir_r | force_out | own_sdd;
  wire [7:0]  is_in     = ~is_out;

  // readback of the latch register
  wire [7:0]  latch_rd  = (dir_r & latch_r) | (~dir_r & sync2_r);

  // read mux
  wire [7:0]  rd_byte   = hit_latch ? latch_rd :
                          hit_pin   ? sync2_r :
                          hit_dir   ? dir_r :
                          hit_pen   ? pull_en_r :
                          hit_pol   ? pull_pol_r :
                          hit_slew  ? slew_r :
                          `PUP_RSVD_VALUE;

  // apb answer, no wait states
  assign prdata  = rdata_r;
  assign pready  = ready_r;
  assign pslverr = ready_r & ~hit_any;

  // pad drive
  assign pad.out      = (own_sdd & alt.sdd_out) | (own_pwm & alt.pwm_out) |
                        (own_tmr & alt.tmr_out) | (own_gpio & latch_r);
  assign pad.oe       = is_out;
  assign pad.pull_up  = pull_en_r & is_in & ~pull_pol_r;
  assign pad.pull_dn  = pull_en_r & is_in & pull_pol_r;
  assign pad.slew_lim = slew_r;
  assign pad.ibe      = ~slew_r;
  assign edge_rise_sel = pull_pol_r;

  // ready and read data capture
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ready_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ready_r <= setup_w;
      rdata_r <= (setup_w & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // pin synchroniser
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= `PUP_RST_BYTE;
      sync2_r <= `PUP_RST_BYTE;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // register writes; pin input and reserved take none
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      latch_r    <= `PUP_RST_BYTE;
      dir_r      <= `PUP_RST_BYTE;
      pull_en_r  <= `PUP_RST_BYTE;
      pull_pol_r <= `PUP_RST_BYTE;
      slew_r     <= `PUP_RST_BYTE;
    end
    else if (wr_w)
    begin
      if (hit_latch) latch_r <= pwdata[7:0];
      if (hit_dir)   dir_r <= pwdata[7:0];
      if (hit_pen)   pull_en_r <= pwdata[7:0];
      if (hit_pol)   pull_pol_r <= pwdata[7:0];
      if (hit_slew)  slew_r <= pwdata[7:0];
      // pin input and reserved writes dropped
    end
  end

endmodule

// file: verification/pup_pins_model.sv
// pads: each wire from own drive, then pull device, then the outside world
`timescale 1ns/1ps
module pup_pins_model (
  input wire pup_pkg::pup_pad_s pad,    // pad controls from the port
  input wire logic [7:0]        ext,    // outside level on floating pins
  output logic [7:0]            pin_in  // resolved wire levels
);
  // drive wins, pulls only on inputs
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & (pad.pull_up | (~pad.pull_dn & ext)));
endmodule

// file: verification/pup_port_bench.sv
// self-checking bench for the port u pin block
`timescale 1ns/1ps
`include "pup_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("FAIL %0t got %h", $time, a); end end
module pup_port_bench;
  logic              clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata;
  logic [7:0]        pin_in, edge_rise_sel, rd, ext = 8'h3c;
  pup_pkg::pup_alt_s alt = '0;
  pup_pkg::pup_pad_s pad;
  int                bad_count = 0, comparisons = 0, cycles = 0;
  always #2 clk_sys = ~clk_sys;
  pup_port dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .alt(alt), .pin_in(pin_in), .pad(pad),
    .edge_rise_sel(edge_rise_sel));
  pup_pins_model pins (.pad(pad), .ext(ext), .pin_in(pin_in));
  // one apb transfer; pready sampled at the rising edge, request released only after it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata[7:0]; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic results();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000) begin bad_count++; results(); end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    `CHK(pad.pull_up | pad.pull_dn, 8'h00)
    rdc(`PUP_OFF_PULL_EN, 8'h00);
    wr(`PUP_OFF_DIR, 8'hf0);
    wr(`PUP_OFF_LATCH, 8'ha5);
    repeat (3) @(posedge clk_sys);
    `CHK(pad.oe, 8'hf0)
    rdc(`PUP_OFF_LATCH, 8'hac);
    rdc(`PUP_OFF_PIN_IN, 8'hac);
    wr(`PUP_OFF_PIN_IN, 8'hff);
    rdc(`PUP_OFF_DIR, 8'hf0);
    wr(`PUP_OFF_RSVD, 8'hff);
    rdc(`PUP_OFF_RSVD, 8'h00);
    xfer(1'b0, 12'h020, 8'h00);
    `CHK(err, 1'b1)
    wr(`PUP_OFF_DIR, 8'h00);
    wr(`PUP_OFF_PULL_EN, 8'hff);
    wr(`PUP_OFF_PULL_POL, 8'h0f);
    repeat (3) @(posedge clk_sys);
    rdc(`PUP_OFF_PIN_IN, 8'hf0);
    `CHK(edge_rise_sel, 8'h0f)
    wr(`PUP_OFF_DIR, 8'hff);
    rdc(`PUP_OFF_LATCH, 8'ha5);
    `CHK(pad.pull_up | pad.pull_dn, 8'h00)
    wr(`PUP_OFF_DIR, 8'h00);
    alt <= '{8'h03, 8'h01, 8'h0f, 8'h0a, 8'hff, 8'h14};
    @(negedge clk_sys);
    `CHK(pad.oe, 8'h5f)
    `CHK(pad.out & pad.oe, 8'h19)
    alt.tmr_en <= 8'h00;
    @(negedge clk_sys);
    `CHK(pad.oe, 8'h0f)
    wr(`PUP_OFF_SLEW, 8'hff);
    @(negedge clk_sys);
    `CHK(pad.ibe, 8'h00)
    results();
  end
endmodule

// file: verification/pup_port_properties.sv
// checker of apb timing, pin ownership and pull rules of the port u block
`timescale 1ns/1ps
module pup_port_properties (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire pup_pkg::pup_alt_s alt,
  input wire logic [7:0]        pin_in,
  input wire pup_pkg::pup_pad_s pad,
  input wire logic [7:0]        edge_rise_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // setup answered in the very next cycle, for one cycle only
  a_ready_next: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad ready timing");
  a_rsvd_zero: assert property (
    pready && !pwrite && paddr == 12'h00c |-> prdata == 32'h0) else $error("reserved read not zero");
  a_pull_input: assert property (
    ((pad.pull_up | pad.pull_dn) & pad.oe) == 8'h00) else $error("pull on output pin");
  a_pull_pol: assert property (
    (pad.pull_dn & ~edge_rise_sel | pad.pull_up & edge_rise_sel) == 8'h00) else $error("pull polarity");
  a_pwm_force: assert property (
    (alt.pwm_en & ~pad.oe) == 8'h00) else $error("pwm pin not output");
  a_sdd_wins: assert property (
    ((pad.out ^ alt.sdd_out) & alt.sdd_en) == 8'h00) else $error("stall drive lost");
  a_pwm_level: assert property (
    ((pad.out ^ alt.pwm_out) & alt.pwm_en & ~alt.sdd_en) == 8'h00) else $error("pwm level lost");
  a_tmr_force: assert property (
    (alt.tmr_en & 8'h55 & ~pad.oe) == 8'h00) else $error("timer pin not output");
  a_slew_ibe: assert property (
    pad.ibe == ~pad.slew_lim) else $error("slew and input buffer");
  c_error: cover property (pready && pslverr);
  c_overlap: cover property (|(alt.sdd_en & alt.pwm_en));
  c_pull_dn: cover property (|pad.pull_dn);
endmodule
bind pup_port pup_port_properties chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .alt(alt), .pin_in(pin_in), .pad(pad), .edge_rise_sel(edge_rise_sel));
